// file: hw/dss_status.sv
/*
 Device status summary and supply fault status registers, plus the
 memory/temperature flags that feed the summary. Read through a plain
 register read port; writes are accepted and ignored.
 Assumes inputs synchronous to i_clk; i_sys_rst is the power-on reset.
*/
//
// Behaviour
// - Summary bit 7 is the OR of the three signal processor error inputs.
// - Summary bit 5 mirrors the link mismatch flag.
// - Summary bit 4 is the OR of all memory/temperature group flags.
// - Summary bit 3 is the OR of all supply group flags.
// - Summary bit 2 shows test mode; cleared only by test operation or power.
// - Summary bit 1 set after any reset, cleared by read or status report.
// - Summary bit 0 set after reset, cleared once sensor data is valid.
// - Supply bit 7 set on supply undervoltage.
// - Supply bit 3 set on analog regulator out of range.
// - Supply bit 2 set on digital regulator out of range.
// - Supply bit 1 set on memory regulator out of range.
// - Supply bit 0 set on edge-seal continuity break.
// - One shared recovery timer, reloaded while any supply fault present.
// - Supply flags clear according to the supply report disable setting.
// - Status registers are read-only; host writes change nothing.
// - Memory/temperature flags except write-active clear on register read or status report.
`timescale 1ns/10ps
module dss_status #(
   parameter int P_VALID_CYC = dss_pkg::VALID_CYC,
   parameter int P_RCV_CYC = dss_pkg::RCV_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_soft_rst,
   // Register port
   input wire logic i_rd_en,
   input wire logic [7:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   // Status field reports
   input wire logic i_reset_reported,
   input wire logic i_memtemp_reported,
   // Signal processor and link
   input wire logic i_selftest_incomplete,
   input wire logic i_common_mode_fault,
   input wire logic i_selftest_fault,
   input wire logic i_comm_fault_status,
   // Test mode
   input wire logic i_test_enter,
   input wire logic i_test_exit,
   // Memory and temperature events
   input wire logic i_factory_nvm_fault,
   input wire logic i_user_nvm_fault,
   input wire logic i_user_reg_fault,
   input wire logic i_nvm_write_active,
   input wire logic i_temp_range_fault,
   // Supply monitors
   input wire logic i_supply_undervoltage,
   input wire logic i_analog_regulator_fault,
   input wire logic i_digital_regulator_fault,
   input wire logic i_nvm_regulator_fault,
   input wire logic i_edge_seal_break,
   input wire logic i_supply_report_disable,
   // Status out
   output logic o_init_in_progress,
   output logic o_supply_fault_any
);
   dss_rcv_if rcv ();
   logic [4:0] sup_r;
   logic [4:0] sup_raw;
   logic [3:0] mt_r;
   logic test_r;
   logic reset_occurred_flag_r;
   logic init_r;
   logic [dss_pkg::TMR_W-1:0] init_cnt_r;
   logic [7:0] summary_w;
   logic [7:0] supply_w;
   logic [7:0] memtemp_w;
   logic rd_sum;
   logic rd_mt;
   logic any_rst;
   logic wr_unused;

   assign any_rst = i_sys_rst || i_soft_rst;
   assign rd_sum = i_rd_en && (i_rd_addr == dss_pkg::ADDR_SUMMARY);
   assign rd_mt = i_rd_en && (i_rd_addr == dss_pkg::ADDR_MEMTEMP);
   // Write port exists for the shared bus only; nothing here is writable
   assign wr_unused = i_wr_en & (|i_wr_addr) & (|i_wr_data);

   // ==========================================================
   // Supply group
   assign sup_raw = {i_supply_undervoltage, i_analog_regulator_fault,
                     i_digital_regulator_fault, i_nvm_regulator_fault,
                     i_edge_seal_break};
   assign rcv.fault_any = |sup_raw;

   dss_rcv_timer #(
      .P_RCV_CYC(P_RCV_CYC)
   ) u_rcv (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .rcv(rcv)
   );

   // Disabled reporting drops a flag as soon as its fault goes; otherwise
   // the flag is held until the shared recovery interval has elapsed.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sup_r <= dss_pkg::RST_SUPPLY;
      end else if (i_supply_report_disable) begin
         sup_r <= sup_raw;
      end else if (rcv.expired) begin
         sup_r <= sup_raw;
      end else begin
         sup_r <= sup_r | sup_raw;
      end
   end

   always_comb begin
      supply_w = dss_pkg::RST_ZERO;
      supply_w[dss_pkg::SUP_UV] = sup_r[4];
      supply_w[dss_pkg::SUP_ANA] = sup_r[3];
      supply_w[dss_pkg::SUP_DIG] = sup_r[2];
      supply_w[dss_pkg::SUP_NVM] = sup_r[1];
      supply_w[dss_pkg::SUP_SEAL] = sup_r[0];
   end

   // ==========================================================
   // Memory and temperature group; set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mt_r <= '0;
      end else if (rd_mt || i_memtemp_reported) begin
         mt_r <= {i_factory_nvm_fault, i_user_nvm_fault, i_user_reg_fault,
                  i_temp_range_fault};
      end else begin
         mt_r <= mt_r | {i_factory_nvm_fault, i_user_nvm_fault, i_user_reg_fault,
                         i_temp_range_fault};
      end
   end

   always_comb begin
      memtemp_w = dss_pkg::RST_ZERO;
      memtemp_w[dss_pkg::MT_FACT] = mt_r[3];
      memtemp_w[dss_pkg::MT_USER] = mt_r[2];
      memtemp_w[dss_pkg::MT_RW] = mt_r[1];
      memtemp_w[dss_pkg::MT_WACT] = i_nvm_write_active;
      memtemp_w[dss_pkg::MT_TEMP] = mt_r[0];
   end

   // ==========================================================
   // Test mode survives soft reset; only test exit or power-on clears it
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         test_r <= 1'b0;
      end else if (i_test_enter) begin
         test_r <= 1'b1;
      end else if (i_test_exit) begin
         test_r <= 1'b0;
      end
   end

   // ==========================================================
   // Reset occurred
   always_ff @(posedge i_clk) begin
      if (any_rst) begin
         reset_occurred_flag_r <= 1'b1;
      end else if (rd_sum || i_reset_reported) begin
         reset_occurred_flag_r <= 1'b0;
      end
   end

   // ==========================================================
   // Initialisation window
   always_ff @(posedge i_clk) begin
      if (any_rst) begin
         init_r <= 1'b1;
         init_cnt_r <= dss_pkg::TMR_W'(P_VALID_CYC);
      end else if (init_cnt_r > dss_pkg::TMR_W'(1)) begin
         init_cnt_r <= init_cnt_r - 1'b1;
      end else begin
         init_cnt_r <= '0;
         init_r <= 1'b0;
      end
   end

   // ==========================================================
   // Summary, built live from current group flags
   always_comb begin
      summary_w = dss_pkg::RST_ZERO;
      summary_w[dss_pkg::SUM_DSP] = i_selftest_incomplete | i_common_mode_fault
                                    | i_selftest_fault;
      summary_w[dss_pkg::SUM_LINK] = i_comm_fault_status;
      summary_w[dss_pkg::SUM_MEMTEMP] = |memtemp_w;
      summary_w[dss_pkg::SUM_SUPPLY] = |sup_r;
      summary_w[dss_pkg::SUM_TEST] = test_r;
      summary_w[dss_pkg::SUM_RESET] = reset_occurred_flag_r;
      summary_w[dss_pkg::SUM_INIT] = init_r;
   end

   // ==========================================================
   // Read data; unmapped addresses return zero
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rd_data <= dss_pkg::RST_ZERO;
      end else if (i_rd_en) begin
         unique case (i_rd_addr)
            dss_pkg::ADDR_SUMMARY: o_rd_data <= summary_w;
            dss_pkg::ADDR_SUPPLY: o_rd_data <= supply_w;
            dss_pkg::ADDR_MEMTEMP: o_rd_data <= memtemp_w;
            default: o_rd_data <= dss_pkg::RST_ZERO;
         endcase
      end
   end

   // Reset window flag lets the host mask supply flags
   assign o_init_in_progress = init_r;
   assign o_supply_fault_any = |sup_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   AST_DSP_SUM: assert property (rd_sum |=> o_rd_data[7] ==
      $past(i_selftest_incomplete | i_common_mode_fault | i_selftest_fault))
      else $error("dsp summary wrong");
   AST_LINK_SUM: assert property (rd_sum |=> o_rd_data[5] == $past(i_comm_fault_status))
      else $error("link summary wrong");
   AST_MT_SUM: assert property (i_factory_nvm_fault |=> summary_w[4])
      else $error("memtemp summary missed");
   AST_SUP_SUM: assert property (rcv.fault_any |=> summary_w[3])
      else $error("supply summary mismatch");
   AST_TEST_HOLD: assert property (test_r && !i_test_exit |=> test_r)
      else $error("test mode lost");
   AST_RES_CLR: assert property (rd_sum && !i_soft_rst |=> !reset_occurred_flag_r)
      else $error("reset flag not cleared");
   AST_INIT_SET: assert property (i_soft_rst |=> init_r && reset_occurred_flag_r)
      else $error("init not set after reset");
   AST_UV_SET: assert property (i_supply_undervoltage |=> supply_w[7])
      else $error("undervoltage not flagged");
   AST_SEAL_SET: assert property (i_edge_seal_break |=> supply_w[0])
      else $error("seal break not flagged");
   AST_SUP_HOLD: assert property (!i_supply_report_disable && rcv.fault_any ##1
      (!rcv.fault_any && !i_supply_report_disable)[*3] |-> o_supply_fault_any)
      else $error("supply flag dropped early");
   AST_SUP_DIS: assert property (i_supply_report_disable && !rcv.fault_any |=>
      !o_supply_fault_any)
      else $error("disabled flag held");
   AST_MT_CLR: assert property (rd_mt && !i_factory_nvm_fault |=> !memtemp_w[7])
      else $error("memtemp not cleared");

   COV_READ_SUM: cover property (rd_sum ##1 o_rd_data[1]);
   COV_SUP_RCV: cover property (rcv.fault_any ##1 !rcv.fault_any ##[1:1000] !o_supply_fault_any);
   COV_INIT_DONE: cover property (init_r ##1 !init_r);
   COV_TEST: cover property (i_test_enter ##[1:20] i_test_exit);
endmodule

// file: hw/dss_pkg.sv
/*
 Constants for the device status summary flags: register offsets, bit
 positions and timing counts. Assumes a 25 MHz core clock.
*/
package dss_pkg;
   // ==========================================================
   // Register offsets and data width
   localparam logic [7:0] ADDR_SUMMARY = 8'h01;
   localparam logic [7:0] ADDR_SUPPLY = 8'h02;
   localparam logic [7:0] ADDR_MEMTEMP = 8'h03;
   localparam logic [7:0] DATA_W = 8'h08;
   // ==========================================================
   // Summary bit positions
   localparam int SUM_DSP = 7;
   localparam int SUM_LINK = 5;
   localparam int SUM_MEMTEMP = 4;
   localparam int SUM_SUPPLY = 3;
   localparam int SUM_TEST = 2;
   localparam int SUM_RESET = 1;
   localparam int SUM_INIT = 0;
   // ==========================================================
   // Supply bit positions
   localparam int SUP_UV = 7;
   localparam int SUP_ANA = 3;
   localparam int SUP_DIG = 2;
   localparam int SUP_NVM = 1;
   localparam int SUP_SEAL = 0;
   // ==========================================================
   // Memory and temperature bit positions
   localparam int MT_FACT = 7;
   localparam int MT_USER = 6;
   localparam int MT_RW = 5;
   localparam int MT_WACT = 4;
   localparam int MT_TEMP = 2;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [4:0] RST_SUPPLY = 5'h00;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 25;
   localparam int RCV_TIME_US = 100;
   localparam int RCV_CYC = RCV_TIME_US * CLK_MHZ;
   localparam int VALID_TIME_US = 1000;
   localparam int VALID_CYC = VALID_TIME_US * CLK_MHZ;
   localparam int TMR_W = 20;
endpackage

// file: hw/dss_rcv_if.sv
/*
 Link between the status top and its supply recovery timer.
 Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface dss_rcv_if;
   logic fault_any;
   logic expired;
   modport owner (output fault_any, input expired);
   modport timer (input fault_any, output expired);
endinterface

// file: hw/dss_rcv_timer.sv
/*
 Shared supply recovery timer. Reloaded while any supply fault is
 present, reports expiry once the interval has run out with no fault.
 Assumes synchronous active-high reset.
*/
`timescale 1ns/10ps
module dss_rcv_timer #(
   parameter int P_RCV_CYC = dss_pkg::RCV_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Timer link
   dss_rcv_if.timer rcv
);
   logic [dss_pkg::TMR_W-1:0] cnt_r;

   // ==========================================================
   // Countdown
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_r <= '0;
      end else if (rcv.fault_any) begin
         cnt_r <= dss_pkg::TMR_W'(P_RCV_CYC);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign rcv.expired = (cnt_r == '0) && !rcv.fault_any;
endmodule

// file: tb/dss_host.sv
/*
 Host model that reads the status registers one byte at a time.
 Assumes the register port of dss_status and a shared clock.
*/
`timescale 1ns/10ps
module dss_host (
   // Clock and status
   input wire logic i_clk,
   input wire logic i_init,
   // Register port
   output logic o_rd_en,
   output logic [7:0] o_rd_addr,
   input wire logic [7:0] i_rd_data
);
   // ==========================================================
   // Read cycle
   initial begin
      o_rd_en = 1'b0;
      o_rd_addr = 8'h00;
   end
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_rd_en <= 1'b1;
      o_rd_addr <= a;
      @(posedge i_clk);
      o_rd_en <= 1'b0;
      // Stale address is not left on the port
      o_rd_addr <= ~a;
      // Data stands until the next read, so the next edge is safe
      @(posedge i_clk);
      d = i_rd_data;
      // Supply flags are not trusted while init runs
      if (i_init && a == dss_pkg::ADDR_SUPPLY) begin
         d = 8'h00;
      end
   endtask
endmodule

// file: tb/device_status_summary_flags_tb.sv
/*
 Self-checking bench for dss_status with a host read model.
 Assumes shortened init and recovery counts set below.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module device_status_summary_flags_tb;
   localparam int VC = 20;
   localparam int RC = 10;
   logic i_clk, i_sys_rst, i_soft_rst, rd_en, wr_en, comm, t_in, t_out, rrep, mrep, dis;
   logic init_o, sup_any;
   logic [7:0] rd_addr, rd_data, wr_addr, wr_data, d;
   logic [2:0] dsp;
   logic [4:0] mt, sup;
   int mismatches, n_tests;
   int mtp[5] = '{dss_pkg::MT_FACT, dss_pkg::MT_USER, dss_pkg::MT_RW, dss_pkg::MT_WACT,
      dss_pkg::MT_TEMP};
   int spp[5] = '{dss_pkg::SUP_UV, dss_pkg::SUP_ANA, dss_pkg::SUP_DIG, dss_pkg::SUP_NVM,
      dss_pkg::SUP_SEAL};
   // ==========================================================
   // Instances
   dss_status #(.P_VALID_CYC(VC), .P_RCV_CYC(RC)) dss_status_i (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_soft_rst(i_soft_rst), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
      .o_rd_data(rd_data), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
      .i_reset_reported(rrep), .i_memtemp_reported(mrep), .i_selftest_incomplete(dsp[0]),
      .i_common_mode_fault(dsp[1]), .i_selftest_fault(dsp[2]), .i_comm_fault_status(comm),
      .i_test_enter(t_in), .i_test_exit(t_out), .i_factory_nvm_fault(mt[0]),
      .i_user_nvm_fault(mt[1]), .i_user_reg_fault(mt[2]), .i_nvm_write_active(mt[3]),
      .i_temp_range_fault(mt[4]), .i_supply_undervoltage(sup[0]),
      .i_analog_regulator_fault(sup[1]), .i_digital_regulator_fault(sup[2]),
      .i_nvm_regulator_fault(sup[3]), .i_edge_seal_break(sup[4]),
      .i_supply_report_disable(dis), .o_init_in_progress(init_o), .o_supply_fault_any(sup_any));
   dss_host dss_host_i (.i_clk(i_clk), .i_init(init_o), .o_rd_en(rd_en), .o_rd_addr(rd_addr),
      .i_rd_data(rd_data));
   // ==========================================================
   // Helpers
   task automatic idle(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      dss_host_i.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_reset();
      `CHK(init_o, 1'b1)
      rchk(dss_pkg::ADDR_SUMMARY, 8'h03);
      rchk(dss_pkg::ADDR_SUMMARY, 8'h01);
      rchk(8'h05, 8'h00);
      @(posedge i_clk);
      wr_en <= 1'b1;
      wr_addr <= dss_pkg::ADDR_SUMMARY;
      wr_data <= 8'hFF;
      @(posedge i_clk);
      wr_en <= 1'b0;
      rchk(dss_pkg::ADDR_SUMMARY, 8'h01);
      idle(VC);
      `CHK(init_o, 1'b0)
      rchk(dss_pkg::ADDR_SUMMARY, 8'h00);
      $display("test_reset done");
   endtask
   task automatic test_summary();
      for (int i = 0; i < 3; i++) begin
         dsp <= 3'h1 << i;
         rchk(dss_pkg::ADDR_SUMMARY, 8'h80);
      end
      dsp <= 3'h0;
      comm <= 1'b1;
      rchk(dss_pkg::ADDR_SUMMARY, 8'h20);
      comm <= 1'b0;
      t_in <= 1'b1;
      @(posedge i_clk);
      t_in <= 1'b0;
      rchk(dss_pkg::ADDR_SUMMARY, 8'h04);
      rchk(dss_pkg::ADDR_SUMMARY, 8'h04);
      t_out <= 1'b1;
      @(posedge i_clk);
      t_out <= 1'b0;
      rchk(dss_pkg::ADDR_SUMMARY, 8'h00);
      $display("test_summary done");
   endtask
   task automatic test_memtemp();
      for (int i = 0; i < 5; i++) begin
         mt <= 5'h01 << i;
         @(posedge i_clk);
         if (i != 3) mt <= 5'h00;
         rchk(dss_pkg::ADDR_SUMMARY, 8'h10);
         rchk(dss_pkg::ADDR_MEMTEMP, 8'h01 << mtp[i]);
         mt <= 5'h00;
         rchk(dss_pkg::ADDR_SUMMARY, 8'h00);
      end
      mt <= 5'h10;
      @(posedge i_clk);
      mt <= 5'h00;
      mrep <= 1'b1;
      @(posedge i_clk);
      mrep <= 1'b0;
      rchk(dss_pkg::ADDR_SUMMARY, 8'h00);
      mt <= 5'h01;
      mrep <= 1'b1;
      @(posedge i_clk);
      mt <= 5'h00;
      mrep <= 1'b0;
      rchk(dss_pkg::ADDR_MEMTEMP, 8'h80);
      $display("test_memtemp done");
   endtask
   task automatic test_supply();
      for (int i = 0; i < 5; i++) begin
         sup <= 5'h01 << i;
         idle(2);
         `CHK(sup_any, 1'b1)
         rchk(dss_pkg::ADDR_SUMMARY, 8'h08);
         sup <= 5'h00;
         rchk(dss_pkg::ADDR_SUPPLY, 8'h01 << spp[i]);
         idle(6);
         sup <= 5'h01 << i;
         @(posedge i_clk);
         sup <= 5'h00;
         idle(6);
         rchk(dss_pkg::ADDR_SUPPLY, 8'h01 << spp[i]);
         idle(RC);
         rchk(dss_pkg::ADDR_SUPPLY, 8'h00);
      end
      dis <= 1'b1;
      sup <= 5'h01;
      idle(2);
      sup <= 5'h00;
      idle(2);
      rchk(dss_pkg::ADDR_SUPPLY, 8'h00);
      dis <= 1'b0;
      $display("test_supply done");
   endtask
   task automatic test_soft();
      i_soft_rst <= 1'b1;
      @(posedge i_clk);
      i_soft_rst <= 1'b0;
      rrep <= 1'b1;
      @(posedge i_clk);
      rrep <= 1'b0;
      rchk(dss_pkg::ADDR_SUMMARY, 8'h01);
      i_soft_rst <= 1'b1;
      @(posedge i_clk);
      i_soft_rst <= 1'b0;
      rchk(dss_pkg::ADDR_SUMMARY, 8'h03);
      $display("test_soft done");
   endtask
   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      {i_sys_rst, i_soft_rst, wr_en, comm, t_in, t_out, rrep, mrep, dis} = 9'h100;
      {wr_addr, wr_data, dsp, mt, sup} = '0;
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      test_reset();
      test_summary();
      test_memtemp();
      test_supply();
      test_soft();
      tally_and_finish();
   end
   initial begin
      // Whole run needs well under a thousand cycles
      repeat (3000) @(posedge i_clk);
      mismatches++;
      tally_and_finish();
   end
endmodule
